// [rtl/hop_enc_pkg.sv]
package hop_enc_pkg;

   // ---------------------------------------------
   // Time base
   // ---------------------------------------------
   localparam int CLK_HZ         = 100_000_000;
   localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
   localparam int PE_LONG_US     = 400;
   localparam int PE_SHORT_US    = 200;
   localparam int DEBOUNCE_MS    = 10;
   localparam int SHUTOFF_MS     = 20_000;
   localparam int PENTRY_MS      = 2;
   localparam int BULK_MS        = 4;
   localparam int PROG_MS        = 4;
   localparam int ACK_HIGH_US    = 800;
   localparam int ACK_LOW_US     = 800;
   localparam int BOOST_KHZ      = 200;
   localparam int PE_LONG_CYC    = PE_LONG_US * CYC_PER_US;
   localparam int PE_SHORT_CYC   = PE_SHORT_US * CYC_PER_US;
   localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * 1000 * CYC_PER_US;
   localparam int SHUTOFF_CYC    = SHUTOFF_MS * 1000 * CYC_PER_US;
   localparam int PENTRY_CYC     = PENTRY_MS * 1000 * CYC_PER_US;
   localparam int BULK_CYC       = BULK_MS * 1000 * CYC_PER_US;
   localparam int PROG_CYC       = PROG_MS * 1000 * CYC_PER_US;
   localparam int ACK_HIGH_CYC   = ACK_HIGH_US * CYC_PER_US;
   localparam int ACK_LOW_CYC    = ACK_LOW_US * CYC_PER_US;
   localparam logic [8:0] BOOST_HALF_CYC = 9'(CLK_HZ / (2 * BOOST_KHZ * 1000));

   // ---------------------------------------------
   // Code word shape, in basic pulse elements and bits
   // ---------------------------------------------
   localparam logic [7:0] PREAMBLE_PE  = 8'h17;
   localparam logic [7:0] HEADER_PE    = 8'h0A;
   localparam logic [7:0] GUARD_PE     = 8'h27;
   localparam logic [7:0] WORD_BITS    = 8'h42;
   localparam logic [7:0] SYNC_BITS    = 8'h52;
   localparam logic [3:0] MIN_WORDS    = 4'h4;
   localparam logic [3:0] MIN_SLOTS_BL = 4'h8;

   // ---------------------------------------------
   // Nonvolatile words and configuration fields
   // ---------------------------------------------
   localparam logic [3:0] MEM_WORDS  = 4'hC;
   localparam logic [7:0] MEM_BITS   = 8'hBF;
   localparam logic [3:0] SYNC_WORD  = 4'h4;
   localparam logic [3:0] SER0_WORD  = 4'h6;
   localparam logic [3:0] SER1_WORD  = 4'h7;
   localparam logic [3:0] SEED0_WORD = 4'h8;
   localparam logic [3:0] SEED1_WORD = 4'h9;
   localparam logic [3:0] DISC_WORD  = 4'hA;
   localparam logic [3:0] CFG_WORD   = 4'hB;
   localparam int CFG_LVS   = 4;
   localparam int CFG_RATE  = 5;
   localparam int CFG_MIN4  = 6;
   localparam int CFG_START = 7;
   localparam int CFG_FORCE = 8;
   localparam int CFG_LSER  = 9;

   // ---------------------------------------------
   // Sampled input positions
   // ---------------------------------------------
   localparam int IN_B0  = 0;
   localparam int IN_B1  = 1;
   localparam int IN_B2  = 2;
   localparam int IN_DAT = 3;
   localparam int IN_C44 = 4;
   localparam int IN_C9  = 5;
   localparam int IN_C67 = 6;
   localparam int IN_REF = 7;

   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam logic [3:0]  REG_CONFIG = 4'h0;
   localparam logic [3:0]  REG_STATUS = 4'h4;
   localparam logic [3:0]  REG_HOP    = 4'h8;
   localparam logic [3:0]  REG_PLAIN  = 4'hC;
   localparam logic [31:0] HOP_RST    = 32'h0000_0000;

   typedef enum logic [12:0] {
      ST_IDLE     = 13'h0001,
      ST_DEBOUNCE = 13'h0002,
      ST_START    = 13'h0004,
      ST_PREAMBLE = 13'h0008,
      ST_HEADER   = 13'h0010,
      ST_DATA     = 13'h0020,
      ST_GUARD    = 13'h0040,
      ST_PENTRY   = 13'h0080,
      ST_ERASE    = 13'h0100,
      ST_PLOAD    = 13'h0200,
      ST_PWRITE   = 13'h0400,
      ST_PACK     = 13'h0800,
      ST_VERIFY   = 13'h1000
   } enc_st_t;

   typedef struct packed {
      logic [7:0]        meta;
      logic [7:0]        sync;
      logic [7:0]        prev;
      enc_st_t           st;
      logic [31:0]       tmr;
      logic [31:0]       press;
      logic [15:0]       pe_cnt;
      logic [7:0]        pos;
      logic [1:0]        phase;
      logic [3:0]        words;
      logic [2:0]        btn;
      logic [81:0]       shreg;
      logic              sync_mode;
      logic              shutoff;
      logic              batt;
      logic              dout;
      logic              oe;
      logic              boost;
      logic [8:0]        boost_cnt;
      logic [11:0][15:0] mem;
      logic [3:0]        waddr;
      logic [15:0]       wbuf;
      logic [7:0]        vbit;
      logic [31:0]       hop;
      logic [31:0]       rdata;
      logic              ack;
   } enc_state_t;

endpackage

// [rtl/hopping_code_encoder_control.sv]
// Function
// [R01] Trip point from low-voltage select and force bit: 00/01 4.4, 10 9, 11 6.75.
// [R02] Rate bit 0: 400 us element, all words; 1: 200 us, every second word.
// [R03] Min-four clear: one word per activation; set: four complete words despite blanking.
// [R04] Start pulse enable: one-element start pulse after debounce, before first preamble.
// [R05] Fourth button bit copies button 2, or is one when forced.
// [R06] Long serial: 32-bit serial; else 28-bit serial plus four button bits.
// [R07] Word: 50% preamble, header, 32 encrypted bits, 34 fixed bits, then guard.
// [R08] Encrypted part built from 4 button, 12 discrimination, 16 counter bits.
// [R09] Fixed part: 2 status bits, 4 button bits, 28-bit serial, in clear.
// [R10] After programming start-up, button 0 or 1 high at clock fall: synchronous mode.
// [R11] Synchronous mode clocked by button 2 input, plus 16 trailing reserved bits.
// [R12] External clock stays at or below 20 kHz, waits for processing.
// [R13] Started word completes after release; holding repeats words.
// [R14] New extra button aborts transmission and restarts with new buttons.
// [R15] Every word carries the low-battery flag against selected trip point.
// [R16] Transmission stops once a button is held past the shutoff timeout.
// [R17] No buttons standby, functions 1-6 hopping code, all three send seed.
// [R18] Boost output pulses while transmitting and supply below reference; else idle.
// [R19] Clock high for set time then data high enters programming and bulk erase.
// [R20] 192 bits shifted as 16-bit words on clock and data, wait per word.
// [R21] After each word, acknowledge pulses on data until clock input drops.
// [R22] Readback allowed once, only right after a complete programming cycle.
// [R23] Press wakes device, waits 10 ms debounce before transmitting.
// [R24] Counter increments after every transmission.
// [R25] Store holds twelve 16-bit words, programmed and verified in word order.
// [R26] Option bits come from one 16-bit configuration word in the store.
// [R27] Blanked word slot keeps data low for full word duration.
// [R28] Trailing reserved bits in synchronous mode are sent as zeros.
`timescale 1ns/1ns
module hopping_code_encoder_control
   import hop_enc_pkg::*;
#(
   parameter int unsigned PE_LONG_CYC_P  = PE_LONG_CYC,
   parameter int unsigned PE_SHORT_CYC_P = PE_SHORT_CYC,
   parameter int unsigned DEBOUNCE_CYC_P = DEBOUNCE_CYC,
   parameter int unsigned SHUTOFF_CYC_P  = SHUTOFF_CYC,
   parameter int unsigned PENTRY_CYC_P   = PENTRY_CYC,
   parameter int unsigned BULK_CYC_P     = BULK_CYC,
   parameter int unsigned PROG_CYC_P     = PROG_CYC,
   parameter int unsigned ACK_HIGH_CYC_P = ACK_HIGH_CYC,
   parameter int unsigned ACK_LOW_CYC_P  = ACK_LOW_CYC
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Button pins
   input  wire logic        button_in_0,
   input  wire logic        button_in_1,
   input  wire logic        button_in_2_prog_clock,
   // Data pin
   input  wire logic        data_in,
   output logic             data_out,
   output logic             data_oe,
   // Analog comparators
   input  wire logic        batt_below_4v4,
   input  wire logic        batt_below_9v,
   input  wire logic        batt_below_6v75,
   input  wire logic        vdd_below_boost_ref,
   output logic             boost_switch,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest
);

   enc_state_t  s;
   enc_state_t  n;
   logic [15:0] cfg;
   logic [2:0]  btn_now;
   logic        bclk;
   logic        bclk_rise;
   logic        bclk_fall;
   logic        pin_dat;
   logic [15:0] pe_len;
   logic        tick;
   logic        trip;
   logic        blank;
   logic [3:0]  need_words;
   logic [7:0]  bits_total;
   logic [31:0] plain;
   logic [31:0] status;
   logic [191:0] memf;

   // ---------------------------------------------
   // Decoding helpers
   // ---------------------------------------------
   function automatic logic is_tx(input enc_st_t st);
      return (st == ST_START) || (st == ST_PREAMBLE) || (st == ST_HEADER) ||
             (st == ST_DATA) || (st == ST_GUARD);
   endfunction

   function automatic logic [3:0] btn_status(input logic [2:0] b);
      return {cfg[CFG_FORCE] | b[2], b};  // [R05]
   endfunction

   function automatic logic [81:0] build_word(input logic [2:0] b, input logic rpt, input logic bl);
      logic [31:0] lo;
      logic [33:0] fx;
      lo = (b == 3'h7) ? {s.mem[SEED1_WORD], s.mem[SEED0_WORD]} : s.hop;  // [R17] [R08]
      if (cfg[CFG_LSER]) begin
         fx = {bl, rpt, s.mem[SER1_WORD], s.mem[SER0_WORD]};  // [R06]
      end else begin
         fx = {bl, rpt, btn_status(b), s.mem[SER1_WORD][11:0], s.mem[SER0_WORD]};  // [R06] [R09]
      end
      return {16'h0000, fx, lo};  // [R07] [R28]
   endfunction

   // ---------------------------------------------
   // Derived terms
   // ---------------------------------------------
   assign cfg        = s.mem[CFG_WORD];  // [R26]
   assign memf       = s.mem;
   assign btn_now    = s.sync[IN_B2:IN_B0];
   assign bclk       = s.sync[IN_B2];
   assign bclk_rise  = s.sync[IN_B2] & ~s.prev[IN_B2];
   assign bclk_fall  = ~s.sync[IN_B2] & s.prev[IN_B2];
   assign pin_dat    = s.sync[IN_DAT];
   assign pe_len     = cfg[CFG_RATE] ? 16'(PE_SHORT_CYC_P) : 16'(PE_LONG_CYC_P);  // [R02]
   // Synchronous mode takes every element from the external clock edge
   assign tick       = s.sync_mode ? bclk_rise : (s.pe_cnt == 16'h0000);  // [R11] [R12]
   assign need_words = cfg[CFG_RATE] ? MIN_SLOTS_BL : MIN_WORDS;  // [R03]
   assign bits_total = s.sync_mode ? SYNC_BITS : WORD_BITS;  // [R11]
   assign plain      = {btn_status(s.btn), s.mem[DISC_WORD][11:0], s.mem[SYNC_WORD]};  // [R08]
   assign status     = {s.mem[SYNC_WORD], 4'h0, s.words, 4'h0, s.shutoff, s.sync_mode, s.batt,
                        is_tx(s.st)};

   always_comb begin
      case ({cfg[CFG_LVS], cfg[CFG_FORCE]})
         2'b10:   trip = s.sync[IN_C9];  // [R01]
         2'b11:   trip = s.sync[IN_C67];  // [R01]
         default: trip = s.sync[IN_C44];  // [R01]
      endcase
   end

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      n      = s;
      n.meta = {vdd_below_boost_ref, batt_below_6v75, batt_below_9v, batt_below_4v4,
                data_in, button_in_2_prog_clock, button_in_1, button_in_0};
      n.sync = s.meta;
      n.prev = s.sync;

      // Press time, shared by shutoff and programming entry
      if (btn_now == 3'h0) begin
         n.press   = 32'h0;
         n.shutoff = 1'b0;
      end else if (s.press != 32'hFFFF_FFFF) begin
         n.press = s.press + 32'h1;
      end
      if (s.press >= SHUTOFF_CYC_P) begin
         n.shutoff = 1'b1;  // [R16]
      end

      // Boost switch runs only inside a transmission
      if (is_tx(s.st) && s.sync[IN_REF]) begin
         if (s.boost_cnt == BOOST_HALF_CYC - 9'h001) begin
            n.boost_cnt = 9'h000;
            n.boost     = ~s.boost;  // [R18]
         end else begin
            n.boost_cnt = s.boost_cnt + 9'h001;
         end
      end else begin
         n.boost_cnt = 9'h000;
         n.boost     = 1'b0;  // [R18]
      end

      if (is_tx(s.st)) begin
         n.pe_cnt = (s.pe_cnt == 16'h0000) ? pe_len - 16'h0001 : s.pe_cnt - 16'h0001;
      end

      case (s.st)
         ST_IDLE: begin
            if (btn_now != 3'h0 && !s.shutoff) begin
               n.st  = ST_DEBOUNCE;
               n.tmr = 32'h0;
            end
         end
         ST_DEBOUNCE: begin
            n.tmr = s.tmr + 32'h1;
            if (bclk && pin_dat && s.press >= PENTRY_CYC_P) begin
               n.st = ST_PENTRY;  // [R19]
            end else if (btn_now == 3'h0) begin
               n.st = ST_IDLE;
            end else if (s.tmr >= DEBOUNCE_CYC_P - 1) begin  // [R23]
               n.st        = cfg[CFG_START] ? ST_START : ST_PREAMBLE;  // [R04]
               n.pos       = 8'h00;
               n.pe_cnt    = pe_len - 16'h0001;
               n.words     = 4'h0;
               n.sync_mode = 1'b0;
               n.btn       = btn_now;
               n.batt      = trip;  // [R15]
               n.shreg     = build_word(btn_now, 1'b0, trip);
            end
         end
         ST_PENTRY: begin
            if (bclk_fall) begin
               if (s.sync[IN_B0] || s.sync[IN_B1]) begin
                  n.st        = cfg[CFG_START] ? ST_START : ST_PREAMBLE;  // [R10]
                  n.pos       = 8'h00;
                  n.words     = 4'h0;
                  n.sync_mode = 1'b1;
                  n.btn       = {1'b0, s.sync[IN_B1], s.sync[IN_B0]};  // [R10]
                  n.batt      = trip;
                  n.shreg     = build_word({1'b0, s.sync[IN_B1], s.sync[IN_B0]}, 1'b0, trip);
               end else begin
                  n.st  = ST_ERASE;
                  n.tmr = 32'h0;
                  n.mem = '0;  // [R19]
               end
            end
         end
         ST_ERASE: begin
            n.tmr = s.tmr + 32'h1;
            if (s.tmr >= BULK_CYC_P - 1) begin
               n.st    = ST_PLOAD;
               n.waddr = 4'h0;
               n.pos   = 8'h00;
            end
         end
         ST_PLOAD: begin
            if (bclk_fall) begin
               n.wbuf = {pin_dat, s.wbuf[15:1]};  // [R20]
               n.pos  = s.pos + 8'h01;
               if (s.pos == 8'h0F) begin
                  n.st  = ST_PWRITE;
                  n.tmr = 32'h0;
               end
            end
         end
         ST_PWRITE: begin
            n.tmr = s.tmr + 32'h1;
            if (s.tmr >= PROG_CYC_P - 1) begin
               n.mem[s.waddr] = s.wbuf;  // [R25]
               n.waddr        = s.waddr + 4'h1;
               n.st           = ST_PACK;
               n.tmr          = 32'h0;
               n.phase        = 2'b01;
            end
         end
         ST_PACK: begin
            n.tmr = s.tmr + 32'h1;
            if (s.tmr >= (s.phase[0] ? ACK_HIGH_CYC_P : ACK_LOW_CYC_P) - 1) begin
               n.tmr      = 32'h0;
               n.phase[0] = ~s.phase[0];  // [R21]
            end
            if (bclk_fall) begin
               n.pos   = 8'h00;
               n.phase = 2'b00;
               n.vbit  = 8'h00;
               // Readback is reachable only from here, once per full program
               n.st    = (s.waddr == MEM_WORDS) ? ST_VERIFY : ST_PLOAD;  // [R21] [R22]
            end
         end
         ST_VERIFY: begin
            if (bclk_fall) begin
               n.vbit = s.vbit + 8'h01;  // [R25]
               if (s.vbit == MEM_BITS) begin
                  n.st = ST_IDLE;  // [R22]
               end
            end
         end
         ST_START: begin
            if (tick) begin
               n.st  = ST_PREAMBLE;
               n.pos = 8'h00;
            end
         end
         ST_PREAMBLE: begin
            if (tick) begin
               n.pos = s.pos + 8'h01;
               if (s.pos == PREAMBLE_PE - 8'h01) begin
                  n.st  = ST_HEADER;  // [R07]
                  n.pos = 8'h00;
               end
            end
         end
         ST_HEADER: begin
            if (tick) begin
               n.pos = s.pos + 8'h01;
               if (s.pos == HEADER_PE - 8'h01) begin
                  n.st    = ST_DATA;  // [R07]
                  n.pos   = 8'h00;
                  n.phase = 2'b00;
               end
            end
         end
         ST_DATA: begin
            if (tick) begin
               if (s.phase == 2'b10) begin
                  n.phase = 2'b00;
                  n.shreg = {1'b0, s.shreg[81:1]};
                  n.pos   = s.pos + 8'h01;
                  if (s.pos == bits_total - 8'h01) begin
                     n.st  = ST_GUARD;  // [R07]
                     n.pos = 8'h00;
                  end
               end else begin
                  n.phase = s.phase + 2'b01;
               end
            end
         end
         ST_GUARD: begin
            if (tick) begin
               n.pos = s.pos + 8'h01;
               if (s.pos == GUARD_PE - 8'h01) begin
                  n.words = (s.words == 4'hF) ? s.words : s.words + 4'h1;
                  if (!s.sync_mode && !s.shutoff &&
                      (btn_now != 3'h0 || (cfg[CFG_MIN4] && n.words < need_words))) begin  // [R13] [R03]
                     n.st    = ST_PREAMBLE;
                     n.pos   = 8'h00;
                     n.batt  = trip;  // [R15]
                     n.shreg = build_word(s.btn, 1'b1, trip);
                  end else begin
                     n.st                = ST_IDLE;  // [R03] [R11]
                     n.sync_mode         = 1'b0;
                     n.mem[SYNC_WORD]    = s.mem[SYNC_WORD] + 16'h0001;  // [R24]
                  end
               end
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // Abort and timeout take precedence over the element sequence
      if (is_tx(s.st) && !s.sync_mode) begin
         if (s.shutoff) begin
            n.st             = ST_IDLE;  // [R16]
            n.mem[SYNC_WORD] = s.mem[SYNC_WORD] + 16'h0001;  // [R24]
         end else if ((btn_now & ~s.btn) != 3'h0) begin
            n.st  = ST_DEBOUNCE;  // [R14]
            n.tmr = 32'h0;
         end
      end

      // Pin level follows the next state, so it comes straight from a flop
      blank = cfg[CFG_RATE] & n.words[0] & ~n.sync_mode;  // [R02] [R27]
      n.oe  = is_tx(n.st) || (n.st == ST_PACK) || (n.st == ST_VERIFY);
      case (n.st)
         ST_START:    n.dout = 1'b1;  // [R04]
         ST_PREAMBLE: n.dout = ~n.pos[0] & ~blank;  // [R07] [R27]
         ST_DATA: begin
            case (n.phase)
               2'b00:   n.dout = ~blank;
               2'b01:   n.dout = ~n.shreg[0] & ~blank;  // [R27]
               default: n.dout = 1'b0;
            endcase
         end
         ST_PACK:     n.dout = n.phase[0];  // [R21]
         ST_VERIFY:   n.dout = memf[n.vbit];  // [R22]
         default:     n.dout = 1'b0;
      endcase

      // Register slave: one wait cycle, read data lands as the wait drops, the write one edge later
      n.ack = (read | write) & ~s.ack;
      if ((read | write) && !s.ack) begin
         case (address)
            REG_CONFIG: n.rdata = {16'h0000, cfg};
            REG_STATUS: n.rdata = status;
            REG_HOP:    n.rdata = s.hop;
            REG_PLAIN:  n.rdata = plain;
            default:    n.rdata = 32'h0000_0000;
         endcase
      end
      if (write && s.ack && address == REG_HOP) begin
         n.hop = writedata;
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s     <= '0;
         s.st  <= ST_IDLE;
         s.hop <= HOP_RST;
      end else begin
         s <= n;
      end
   end

   assign data_out     = s.dout;
   assign data_oe      = s.oe;
   assign boost_switch = s.boost;
   assign readdata     = s.rdata;
   assign waitrequest  = (read | write) & ~s.ack;

endmodule

// [sim/hop_enc_chk.sv]
`timescale 1ns/1ns
module hop_enc_chk
   import hop_enc_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Pins
   input wire logic        button_in_0,
   input wire logic        data_oe,
   input wire logic        boost_switch,
   // Register bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic req = read | write;
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   property p_wait_first;
      req && !$past(req) |-> waitrequest;
   endproperty
   property p_wait_one;
      req && waitrequest |=> !waitrequest;
   endproperty
   property p_wait_idle;
      !req |-> !waitrequest;
   endproperty
   property p_rd_hold;
      read && !waitrequest ##1 !req |-> $stable(readdata);
   endproperty
   property p_unmapped;
      read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0;
   endproperty
   property p_cfg_width;
      read && !waitrequest && address == REG_CONFIG |-> readdata[31:16] == 16'h0;
   endproperty
   // Three idle cycles leave room for the registered switch to settle
   property p_boost_idle;
      !data_oe [*3] |-> !boost_switch;
   endproperty
   property p_boost_half;
      $rose(boost_switch) |=> (boost_switch || !data_oe) [*8];
   endproperty
   property p_debounce;
      $rose(data_oe) && button_in_0 |-> $past(button_in_0, 40);
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
   a_wait_one:   assert property (p_wait_one) else $error("more than one wait cycle");
   a_wait_idle:  assert property (p_wait_idle) else $error("wait without request");
   a_rd_hold:    assert property (p_rd_hold) else $error("read data moved");
   a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
   a_cfg_width:  assert property (p_cfg_width) else $error("config upper half set");
   a_boost_idle: assert property (p_boost_idle) else $error("boost while idle");
   a_boost_half: assert property (p_boost_half) else $error("boost half too short");
   a_debounce:   assert property (p_debounce) else $error("sent before debounce");
   c_read:  cover property (read && !waitrequest);
   c_send:  cover property ($rose(data_oe));
   c_boost: cover property ($rose(boost_switch));
endmodule
bind hopping_code_encoder_control hop_enc_chk i_chk (
   .clock(clock), .rst(rst), .button_in_0(button_in_0), .data_oe(data_oe),
   .boost_switch(boost_switch), .address(address), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest));

// [sim/hop_prog_model.sv]
`timescale 1ns/1ns
module hop_prog_model (
   // Clock
   input wire logic clock,
   // Encoder pins
   input wire logic data_pin,
   output logic     pclk,
   output logic     pdat
);
   initial begin
      pclk = 1'b0;
      pdat = 1'b0;
   end
   // One 90 ns link period; data changes at the rise, is taken at the fall
   task automatic xfer(input logic b, output logic s);
      @(posedge clock);
      pclk <= 1'b1;
      pdat <= b;
      repeat (4) @(posedge clock);
      s = data_pin;
      pclk <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic enter();
      @(posedge clock);
      pclk <= 1'b1;
      repeat (60) @(posedge clock);
      pdat <= 1'b1;
      repeat (8) @(posedge clock);
      pclk <= 1'b0;
      // Clock stands still while the bulk erase runs
      repeat (80) @(posedge clock);
   endtask
   task automatic word(input logic [15:0] w);
      logic s;
      for (int i = 0; i < 16; i++) xfer(w[i], s);
      repeat (100) @(posedge clock);
   endtask
endmodule

// [sim/hopping_code_encoder_control_tb.sv]
`timescale 1ns/1ns
module hopping_code_encoder_control_tb;
   import hop_enc_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        b0 = 1'b0;
   logic        b1 = 1'b0, lo44 = 1'b1, lo9 = 1'b0, lo675 = 1'b0, vref = 1'b1;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic        waitrequest, data_out, data_oe, boost_switch, pclk, pdat, s;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n;
   // Device drive wins the shared data pin
   wire logic data_in = data_oe ? data_out : pdat;
   hop_prog_model m (.clock(clock), .data_pin(data_in), .pclk(pclk), .pdat(pdat));
   // Debounce outlasts the entry hold, so the programmer can raise data before a send starts
   localparam int EL = 40, DEB = 100, STEP = 50, ACK = 20;
   hopping_code_encoder_control #(.PE_LONG_CYC_P(EL), .PE_SHORT_CYC_P(EL / 2), .DEBOUNCE_CYC_P(DEB),
      .PENTRY_CYC_P(STEP), .BULK_CYC_P(STEP), .PROG_CYC_P(STEP), .ACK_HIGH_CYC_P(ACK), .ACK_LOW_CYC_P(ACK)) i_dut (
      .clock(clock), .rst(rst), .button_in_0(b0), .button_in_1(b1), .button_in_2_prog_clock(pclk),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .batt_below_4v4(lo44),
      .batt_below_9v(lo9), .batt_below_6v75(lo675), .vdd_below_boost_ref(vref),
      .boost_switch(boost_switch), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   initial begin
      forever #5 clock = ~clock;
   end
   function automatic logic [15:0] wv(input int i);
      return (i == 11) ? 16'h0080 : 16'h3C00 + 16'(i);
   endfunction
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      do @(posedge clock); while (waitrequest !== 1'b0);
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      bus(1'b1, REG_HOP, 32'hA5C3_1E0F, q);
      bus(1'b0, REG_HOP, 32'h0, q);
      chk(q, 32'hA5C3_1E0F);
      bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b0, 4'h6, 32'h0, q);
      chk(q, 32'h0);
      m.enter();
      for (int i = 0; i < 12; i++) begin
         m.word(wv(i));
         chk(32'(data_oe), 32'h1);
         m.xfer(1'b0, s);
      end
      for (int k = 0; k < 192; k++) begin
         m.xfer(1'b0, s);
         chk(32'(s), 32'(wv(k / 16)[k % 16]));
      end
      bus(1'b0, REG_CONFIG, 32'h0, q);
      chk(q, 32'h0000_0080);
      b0 <= 1'b1;
      n = 0;
      while (data_oe !== 1'b1 && n < 300) begin
         @(posedge clock);
         n++;
      end
      chk(32'(n >= DEB && n <= DEB + 8), 32'h1);
      repeat (60) @(posedge clock);
      chk(32'(data_out), 32'h1);
      // Release early: the started word must still be running 5000 cycles later
      b0 <= 1'b0;
      repeat (5000) @(posedge clock);
      chk(32'(data_oe), 32'h1);
      // Extra button aborts; the new send takes button 1 and the trip level then seen
      b1 <= 1'b1;
      lo44 <= 1'b0;
      lo9 <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(data_oe), 32'h0);
      repeat (200) @(posedge clock);
      b1 <= 1'b0;
      n = 0;
      while (data_oe === 1'b1 && n < 20000) begin
         @(posedge clock);
         n++;
      end
      chk(32'(data_oe), 32'h0);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk(q & 32'hFFFF_0F0B, 32'h3C05_0100);
      bus(1'b0, REG_PLAIN, 32'h0, q);
      chk(q, 32'h2C0A_3C05);
      // Button 0 held at the clock fall selects synchronous mode
      b0 <= 1'b1;
      m.enter();
      b0 <= 1'b0;
      repeat (318) m.xfer(1'b0, s);
      chk(32'(data_oe), 32'h1);
      m.xfer(1'b0, s);
      chk(32'(data_oe), 32'h0);
      bus(1'b0, REG_PLAIN, 32'h0, q);
      chk(q, 32'h1C0A_3C06);
      conclude();
   end
   // The run needs about 25k cycles; this limit is far past that
   initial begin
      #600_000;
      fail_count++;
      conclude();
   end
endmodule
